// ---- src/adma_pkg.sv ----
// Constants and types shared by the DRAM module access controller.
package adma_pkg;
    localparam int CLK_NS      = 4;
    localparam int ROW_W       = 12;
    localparam int COL_W       = 11;
    localparam int ADDR_W      = 22;
    localparam int DATA_W      = 32;
    localparam int PAR_W       = 4;
    localparam int WORD_W      = DATA_W + PAR_W;
    localparam int STRB_W      = 4;
    localparam int REQ_W       = 1 + ADDR_W + WORD_W;
    localparam int FIFO_DEPTH  = 16;
    localparam int SYNC_STAGES = 2;
    localparam int INIT_REFS   = 8;
    localparam int REF_ROWS    = 4096;
    localparam int T_INIT_US   = 200;
    localparam int T_REF_MS    = 256;
    localparam int T_RC_NS     = 130;
    localparam int T_RCD_NS    = 20;
    localparam int T_RCD_MX_NS = 45;
    localparam int T_RAS_NS    = 70;
    localparam int T_RP_NS     = 50;
    localparam int T_RAC_NS    = 70;
    localparam int T_CPRH_NS   = 40;
    localparam int T_WP_NS     = 15;
    localparam int T_WL_NS     = 20;
    localparam int INIT_CYC    = T_INIT_US * 1000 / CLK_NS;
    localparam int REF_INT_CYC = T_REF_MS * 1000000 / REF_ROWS / CLK_NS;
    localparam int RC_CYC      = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCD_CYC     = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCD_MX_CYC  = T_RCD_MX_NS / CLK_NS;
    localparam int RAS_CYC     = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAC_CYC     = (T_RAC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CPRH_CYC    = (T_CPRH_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WL_CYC      = (T_WL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAS_LOW_CYC = RAC_CYC - RCD_CYC + SYNC_STAGES + 1;
    localparam int REF_RP_CYC  = (RC_CYC - RAS_CYC > RP_CYC) ? RC_CYC - RAS_CYC : RP_CYC;
    typedef enum logic [2:0] {
        ST_INIT, ST_IDLE, ST_ROW, ST_COL, ST_PRE_COL, ST_PRE_ROW, ST_REF
    } adma_state_type;
endpackage : adma_pkg

// ---- src/adma_ctrl.sv ----
// Request FIFO and fast-page DRAM module controller.
module adma_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (in_valid && in_ready)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_valid && out_ready)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : adma_fifo

// Contract
// - Wait 200 us after power-up, then give 8 row-only refreshes before access.
// - If the internal counter is used, init with 8 column-before-row refreshes.
// - Page read: row low, write high, column pulses, row then columns; data each.
// - Page write: row low, write low, column pulses, row then columns; data stored.
// - Successive random cycles start at least 110 or 130 ns apart.
// - Row-to-column strobe delay at least 20 ns, at most 45 or 50 ns.
// - Column strobe high at least 5 ns before the row strobe falls.
// - Write enable low pulse lasts at least 15 ns.
// - Write enable low at least 15 or 20 ns before row strobe rises.
// - Write enable low at least 15 or 20 ns before column strobe rises.
// - Column address valid 30 or 35 ns before row strobe rises in a read.
// - Issue 4096 refreshes in every 256 ms.
// - 12 row and 11 column bits; top row bit repeats as top column bit.
module adma_ctrl #(
    parameter int INIT_WAIT_CYC = adma_pkg::INIT_CYC,
    parameter int REF_GAP_CYC   = adma_pkg::REF_INT_CYC
)(
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          req_write,
    input  wire logic [adma_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [adma_pkg::WORD_W-1:0]   req_wdata,
    output logic                               rd_valid,
    output logic      [adma_pkg::WORD_W-1:0]   rd_data,
    output logic                               init_done,
    output logic      [adma_pkg::STRB_W-1:0]   row_strobe_n,
    output logic      [adma_pkg::STRB_W-1:0]   column_strobe_n,
    output logic                               write_enable_n,
    output logic      [adma_pkg::ROW_W-1:0]    mux_address,
    input  wire logic [adma_pkg::DATA_W-1:0]   data_lines_i,
    output logic      [adma_pkg::DATA_W-1:0]   data_lines_o,
    output logic                               data_lines_oe_n,
    input  wire logic [adma_pkg::PAR_W-1:0]    parity_lines_i,
    output logic      [adma_pkg::PAR_W-1:0]    parity_lines_o,
    output logic                               parity_lines_oe_n
);
    import adma_pkg::*;

    localparam logic [15:0] INIT_LOAD = 16'(INIT_WAIT_CYC - 1);
    localparam logic [15:0] GAP_LOAD  = 16'(REF_GAP_CYC - 1);
    localparam int A_RCD = RCD_CYC;
    localparam int A_RC  = RC_CYC;
    localparam int A_WL  = WL_CYC;
    localparam int A_CAS = CAS_LOW_CYC;
    localparam int A_RAC = RAC_CYC + SYNC_STAGES;

    adma_state_type      state_q;
    logic [15:0]         cnt_q;
    logic [15:0]         ref_tmr_q;
    logic                ref_pend_q;
    logic [3:0]          ref_left_q;
    logic [ROW_W-1:0]    ref_row_q;
    logic [ROW_W-1:0]    open_row_q;
    logic                cur_wr_q;
    logic                ras_n_q;
    logic                cas_n_q;
    logic                we_n_q;
    logic                doe_n_q;
    logic [ROW_W-1:0]    addr_q;
    logic [WORD_W-1:0]   dout_q;
    logic [WORD_W-1:0]   din_s1_q;
    logic [WORD_W-1:0]   din_s2_q;
    logic                init_done_q;
    logic                rd_valid_q;
    logic [WORD_W-1:0]   rd_data_q;
    logic                f_valid;
    logic                f_pop;
    logic [REQ_W-1:0]    f_data;
    logic                h_wr;
    logic [ROW_W-1:0]    h_row;
    logic [ROW_W-1:0]    h_col;
    logic [WORD_W-1:0]   h_wdata;
    logic                page_hit;
    logic                ras_p_q;
    logic [7:0]          lo_cnt_q;
    logic [7:0]          rc_cnt_q;
    logic [3:0]          init_refs_q;

    adma_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   ({req_write, req_addr, req_wdata}),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    assign h_wr    = f_data[REQ_W-1];
    assign h_row   = f_data[REQ_W-2 -: ROW_W];
    assign h_col   = {1'b0, f_data[REQ_W-2], f_data[WORD_W +: COL_W-1]};
    assign h_wdata = f_data[WORD_W-1:0];
    // A refresh that is due closes the page, which also bounds the row low time.
    assign page_hit = f_valid && !ref_pend_q && (h_row == open_row_q)
                      && (h_wr == cur_wr_q);
    assign f_pop = (cnt_q == '0) && ((state_q == ST_ROW)
                   || ((state_q == ST_PRE_COL) && page_hit));

    assign row_strobe_n      = {STRB_W{ras_n_q}};
    assign column_strobe_n   = {STRB_W{cas_n_q}};
    assign write_enable_n    = we_n_q;
    assign mux_address       = addr_q;
    assign data_lines_o      = dout_q[DATA_W-1:0];
    assign parity_lines_o    = dout_q[WORD_W-1:DATA_W];
    assign data_lines_oe_n   = doe_n_q;
    assign parity_lines_oe_n = doe_n_q;
    assign init_done         = init_done_q;
    assign rd_valid          = rd_valid_q;
    assign rd_data           = rd_data_q;

    always_ff @(posedge core_clk)
    begin
        din_s1_q <= {parity_lines_i, data_lines_i};
        din_s2_q <= din_s1_q;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ref_tmr_q  <= GAP_LOAD;
            ref_pend_q <= 1'b0;
        end
        else
        begin
            ref_tmr_q <= (ref_tmr_q == '0) ? GAP_LOAD : ref_tmr_q - 16'h0001;
            if (ref_tmr_q == '0)
            begin
                ref_pend_q <= 1'b1;
            end
            else if (state_q == ST_IDLE)
            begin
                ref_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end
        else
        begin
            // Sampling after a full row access plus the synchroniser covers
            // both the column and the address governed access paths.
            rd_valid_q <= (state_q == ST_COL) && (cnt_q == '0) && !cur_wr_q;
            if ((state_q == ST_COL) && (cnt_q == '0) && !cur_wr_q)
            begin
                rd_data_q <= din_s2_q;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q     <= ST_INIT;
            cnt_q       <= INIT_LOAD;
            ras_n_q     <= 1'b1;
            cas_n_q     <= 1'b1;
            we_n_q      <= 1'b1;
            doe_n_q     <= 1'b1;
            addr_q      <= '0;
            dout_q      <= '0;
            open_row_q  <= '0;
            cur_wr_q    <= 1'b0;
            ref_row_q   <= '0;
            ref_left_q  <= '0;
            init_done_q <= 1'b0;
        end
        else
        begin
            if (cnt_q != '0)
            begin
                cnt_q <= cnt_q - 16'h0001;
            end
            case (state_q)
                ST_INIT:
                begin
                    if (cnt_q == '0)
                    begin
                        // Row-only refresh is used, so no column-first count applies.
                        ref_left_q <= 4'(INIT_REFS - 1);
                        ras_n_q    <= 1'b0;
                        addr_q     <= ref_row_q;
                        cnt_q      <= 16'(RAS_CYC - 1);
                        state_q    <= ST_REF;
                    end
                end
                ST_IDLE:
                begin
                    if (ref_pend_q)
                    begin
                        ras_n_q <= 1'b0;
                        addr_q  <= ref_row_q;
                        cnt_q   <= 16'(RAS_CYC - 1);
                        state_q <= ST_REF;
                    end
                    else if (f_valid)
                    begin
                        ras_n_q    <= 1'b0;
                        we_n_q     <= !h_wr;
                        addr_q     <= h_row;
                        open_row_q <= h_row;
                        cur_wr_q   <= h_wr;
                        cnt_q      <= 16'(RCD_CYC - 1);
                        state_q    <= ST_ROW;
                    end
                end
                ST_ROW, ST_PRE_COL:
                begin
                    if (cnt_q == '0)
                    begin
                        if ((state_q == ST_ROW) || page_hit)
                        begin
                            cas_n_q <= 1'b0;
                            addr_q  <= h_col;
                            dout_q  <= h_wdata;
                            doe_n_q <= !h_wr;
                            cnt_q   <= 16'(CAS_LOW_CYC - 1);
                            state_q <= ST_COL;
                        end
                        else
                        begin
                            ras_n_q <= 1'b1;
                            we_n_q  <= 1'b1;
                            cnt_q   <= 16'(RP_CYC - 1);
                            state_q <= ST_PRE_ROW;
                        end
                    end
                end
                ST_COL:
                begin
                    if (cnt_q == '0)
                    begin
                        cas_n_q <= 1'b1;
                        doe_n_q <= 1'b1;
                        cnt_q   <= 16'(CPRH_CYC - 1);
                        state_q <= ST_PRE_COL;
                    end
                end
                ST_REF:
                begin
                    if (cnt_q == '0)
                    begin
                        ras_n_q   <= 1'b1;
                        ref_row_q <= ref_row_q + 1'b1;
                        // A refresh row pulse is short, so precharge stretches to the full cycle.
                        cnt_q     <= 16'(REF_RP_CYC - 1);
                        state_q   <= ST_PRE_ROW;
                    end
                end
                ST_PRE_ROW:
                begin
                    if ((cnt_q == '0) && (ref_left_q != '0))
                    begin
                        ref_left_q <= ref_left_q - 1'b1;
                        ras_n_q    <= 1'b0;
                        addr_q     <= ref_row_q;
                        cnt_q      <= 16'(RAS_CYC - 1);
                        state_q    <= ST_REF;
                    end
                    else if (cnt_q == '0)
                    begin
                        init_done_q <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ras_p_q     <= 1'b1;
            lo_cnt_q    <= '0;
            rc_cnt_q    <= 8'hFF;
            init_refs_q <= '0;
        end
        else
        begin
            ras_p_q  <= ras_n_q;
            lo_cnt_q <= ras_n_q ? 8'h00 : lo_cnt_q + {7'h00, lo_cnt_q != 8'hFF};
            rc_cnt_q <= (ras_p_q && !ras_n_q) ? 8'h01
                        : rc_cnt_q + {7'h00, rc_cnt_q != 8'hFF};
            if (ras_p_q && !ras_n_q && !init_done_q)
            begin
                init_refs_q <= init_refs_q + 1'b1;
            end
        end
    end

    AST_INIT_COUNT: assert property (@(posedge core_clk) disable iff (reset)
        $rose(init_done_q) |-> init_refs_q == 4'(INIT_REFS))
        else $error("init refresh count wrong");
    AST_INIT_NO_CAS: assert property (@(posedge core_clk) disable iff (reset)
        !init_done_q |-> cas_n_q)
        else $error("column strobe low before init done");
    AST_RC: assert property (@(posedge core_clk) disable iff (reset)
        (ras_p_q && !ras_n_q) |-> rc_cnt_q >= A_RC)
        else $error("cycle time too short");
    AST_RCD: assert property (@(posedge core_clk) disable iff (reset)
        ($fell(ras_n_q) && state_q == ST_ROW) |-> ##A_RCD $fell(cas_n_q))
        else $error("row to column delay wrong");
    AST_CRP: assert property (@(posedge core_clk) disable iff (reset)
        $fell(ras_n_q) |-> cas_n_q && $past(cas_n_q, 2))
        else $error("column strobe not high before row falls");
    AST_WE_PULSE: assert property (@(posedge core_clk) disable iff (reset)
        $fell(we_n_q) |-> (!we_n_q)[*4])
        else $error("write pulse too short");
    AST_RWL: assert property (@(posedge core_clk) disable iff (reset)
        ($rose(ras_n_q) && !$past(we_n_q)) |-> $past(we_n_q, A_WL) == 1'b0)
        else $error("write to row lead too short");
    AST_CWL: assert property (@(posedge core_clk) disable iff (reset)
        ($rose(cas_n_q) && !we_n_q) |-> $past(we_n_q, A_WL) == 1'b0)
        else $error("write to column lead too short");
    AST_READ: assert property (@(posedge core_clk) disable iff (reset)
        ($fell(cas_n_q) && we_n_q) |-> ##A_CAS rd_valid_q && $rose(cas_n_q))
        else $error("read sample misplaced");
    AST_RAC: assert property (@(posedge core_clk) disable iff (reset)
        rd_valid_q |-> lo_cnt_q >= A_RAC)
        else $error("read sampled before access time");
    AST_COL_MSB: assert property (@(posedge core_clk) disable iff (reset)
        $fell(cas_n_q) |-> addr_q[COL_W-1] == open_row_q[ROW_W-1])
        else $error("column top bit not row top bit");
    AST_RELEASE: assert property (@(posedge core_clk) disable iff (reset)
        (ras_n_q || state_q == ST_REF) |-> doe_n_q)
        else $error("data driven outside an access");
    AST_REF_BOUND: assert property (@(posedge core_clk) disable iff (reset)
        (init_done_q && $rose(ref_pend_q)) |-> ##[1:100] !ref_pend_q)
        else $error("refresh not served in time");
    COV_PAGE_READ: cover property (@(posedge core_clk) disable iff (reset)
        $fell(cas_n_q) && we_n_q && lo_cnt_q > 8'(A_CAS + A_RCD));
    COV_WRITE: cover property (@(posedge core_clk) disable iff (reset)
        $fell(cas_n_q) && !we_n_q);
    COV_REFRESH: cover property (@(posedge core_clk) disable iff (reset)
        init_done_q && state_q == ST_REF);
endmodule : adma_ctrl

// ---- sim/adma_dram_model.sv ----
// Behavioural model of the DRAM module that watches the controller's pin timing.
module adma_dram_model
    import adma_pkg::*;
#(
    parameter real T_INIT_NS = 80.0
)(
    input  wire logic [adma_pkg::STRB_W-1:0] row_strobe_n,
    input  wire logic [adma_pkg::STRB_W-1:0] column_strobe_n,
    input  wire logic                        write_enable_n,
    input  wire logic [adma_pkg::ROW_W-1:0]  mux_address,
    input  wire logic [adma_pkg::DATA_W-1:0] data_lines_o,
    input  wire logic                        data_lines_oe_n,
    input  wire logic [adma_pkg::PAR_W-1:0]  parity_lines_o,
    output logic      [adma_pkg::DATA_W-1:0] data_lines_i,
    output logic      [adma_pkg::PAR_W-1:0]  parity_lines_i,
    output int                               err_count,
    output int                               ref_count
);
    timeunit 1ns;
    timeprecision 100ps;
    import adma_pkg::*;
    logic [WORD_W-1:0] mem [logic [ROW_W+COL_W-1:0]];
    logic [ROW_W-1:0]  row_q;
    logic [COL_W-1:0]  col_q;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] last_word;
    logic [WORD_W-1:0] pin_word;
    logic              rd_on;
    logic              col_seen;
    logic              wr_cyc;
    logic              rd_cyc;
    realtime           ras_fall_t;
    realtime           cas_rise_t;
    realtime           we_fall_t;
    realtime           addr_t;
    initial
    begin
        {err_count, ref_count, rd_on, col_seen, wr_cyc, rd_cyc} = '0;
        last_word = '0;
        ras_fall_t = -1000.0;
        cas_rise_t = -1000.0;
        we_fall_t  = -1000.0;
        addr_t     = -1000.0;
    end
    // Undriven lines show the inverse of the last value so a stale sample cannot pass.
    always @*
    begin
        if (!data_lines_oe_n)
            pin_word = {parity_lines_o, data_lines_o};
        else if (rd_on)
            pin_word = rd_word;
        else
            pin_word = ~last_word;
    end
    assign {parity_lines_i, data_lines_i} = pin_word;
    always @(posedge data_lines_oe_n) last_word = {parity_lines_o, data_lines_o};
    always @(negedge rd_on) last_word = rd_word;
    always @(mux_address) addr_t = $realtime;
    always @(negedge write_enable_n) we_fall_t = $realtime;
    always @(posedge write_enable_n)
        if ($realtime - we_fall_t < 15.0) err_count++;
    always @(negedge row_strobe_n[0])
    begin
        if ($realtime < T_INIT_NS) err_count++;
        if (col_seen && $realtime - ras_fall_t < 130.0) err_count++;
        if (column_strobe_n[0] !== 1'b1 || $realtime - cas_rise_t < 5.0) err_count++;
        ras_fall_t = $realtime;
        {col_seen, wr_cyc, rd_cyc} = '0;
        // Strobe and address move in one step, so the address is read once settled.
        #1;
        row_q = mux_address;
    end
    always @(posedge row_strobe_n[0])
    begin
        if (!col_seen && ras_fall_t >= 0.0) ref_count++;
        if (wr_cyc && $realtime - we_fall_t < 20.0) err_count++;
        if (rd_cyc && addr_t < $realtime && $realtime - addr_t < 35.0) err_count++;
    end
    always @(posedge column_strobe_n[0])
    begin
        cas_rise_t = $realtime;
        if (wr_cyc && $realtime - we_fall_t < 20.0) err_count++;
        rd_on <= #3 1'b0;
    end
    always @(negedge column_strobe_n[0])
    begin
        if (ref_count < 8) err_count++;
        if (!col_seen && $realtime - ras_fall_t < 20.0) err_count++;
        col_seen = 1'b1;
        #1;
        col_q = mux_address[COL_W-1:0];
        if (col_q[COL_W-1] !== row_q[ROW_W-1]) err_count++;
        if (!write_enable_n)
        begin
            wr_cyc = 1'b1;
            #7;
            mem[{row_q, col_q}] = pin_word;
        end
        else
        begin
            rd_cyc = 1'b1;
            rd_word = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : '0;
            // Data follows the column strobe, the slower of the access paths here.
            rd_on <= #19 1'b1;
        end
    end
endmodule : adma_dram_model

// ---- sim/async_dram_module_access_bench.sv ----
// Self-checking bench for the DRAM module access controller.
module async_dram_module_access_bench
    import adma_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int INIT_W = 20;
    localparam int REF_G  = 300;
    localparam int NREQ   = 21;
    logic              core_clk = 1'b0;
    logic              reset = 1'b1;
    logic              req_valid = 1'b0;
    logic              req_ready;
    logic              req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [WORD_W-1:0] req_wdata = '0;
    logic              rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic              init_done;
    logic [STRB_W-1:0] row_strobe_n;
    logic [STRB_W-1:0] column_strobe_n;
    logic              write_enable_n;
    logic [ROW_W-1:0]  mux_address;
    logic [DATA_W-1:0] data_lines_i;
    logic [DATA_W-1:0] data_lines_o;
    logic              data_lines_oe_n;
    logic [PAR_W-1:0]  parity_lines_i;
    logic [PAR_W-1:0]  parity_lines_o;
    logic              parity_lines_oe_n;
    int                err_count;
    int                ref_count;
    int                failures = 0;
    int                checked = 0;
    logic [WORD_W-1:0] rd_seen [$];
    always #2 core_clk = ~core_clk;
    adma_ctrl #(.INIT_WAIT_CYC(INIT_W), .REF_GAP_CYC(REF_G)) dut (
        .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_enable_n(write_enable_n), .mux_address(mux_address),
        .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
        .data_lines_oe_n(data_lines_oe_n), .parity_lines_i(parity_lines_i),
        .parity_lines_o(parity_lines_o), .parity_lines_oe_n(parity_lines_oe_n));
    // Reset ends just after the twentieth edge, so the power-up wait is measured from there.
    adma_dram_model #(.T_INIT_NS((INIT_W + 19) * CLK_NS)) dram (
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_enable_n(write_enable_n), .mux_address(mux_address),
        .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n),
        .parity_lines_o(parity_lines_o), .data_lines_i(data_lines_i),
        .parity_lines_i(parity_lines_i), .err_count(err_count), .ref_count(ref_count));
    always @(posedge core_clk)
        if (rd_valid === 1'b1) rd_seen.push_back(rd_data);
    function automatic logic [WORD_W-1:0] word_of(input int i);
        return {4'(~i), 16'hC3A0, 16'(i * 7)};
    endfunction : word_of
    // Groups of four share a row so the page path is taken; row bit 11 toggles per group.
    function automatic logic [ADDR_W-1:0] addr_of(input int i);
        return {1'(i >> 2), 11'(i >> 3), 10'(i * 5)};
    endfunction : addr_of
    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %0t: seen %h expected %h", $realtime, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Called just after an edge; leaves the request up so back-to-back pushes never glitch.
    task automatic push(input logic wr, input int i, inout logic saw_full);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = addr_of(i);
        req_wdata = word_of(i);
        for (int n = 0; n < 2000; n++)
        begin
            @(posedge core_clk);
            if (req_ready === 1'b1) break;
            saw_full = 1'b1;
        end
        #1;
    endtask : push
    task automatic req_idle();
        req_valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : req_idle
    task automatic t_reset_init();
        logic full;
        full = 1'b0;
        check(36'(row_strobe_n & column_strobe_n), 36'hF);
        check(36'({write_enable_n, data_lines_oe_n, parity_lines_oe_n, init_done}), 36'hE);
        push(1'b1, 0, full);
        req_idle();
        for (int n = 0; n < 2000 && init_done !== 1'b1; n++) @(posedge core_clk);
        #1;
        check(36'(init_done), 36'h1);
        check(36'(ref_count), 36'h8);
    endtask : t_reset_init
    task automatic t_fill_write();
        logic full;
        full = 1'b0;
        for (int i = 1; i < NREQ; i++) push(1'b1, i, full);
        req_idle();
        check(36'(full), 36'h1);
    endtask : t_fill_write
    task automatic t_fill_read();
        logic full;
        full = 1'b0;
        for (int i = 0; i < NREQ; i++) push(1'b0, i, full);
        req_idle();
        for (int n = 0; n < 5000 && rd_seen.size() < NREQ; n++) @(posedge core_clk);
        check(36'(rd_seen.size()), 36'(NREQ));
        for (int i = 0; i < NREQ && rd_seen.size() > 0; i++)
            check(rd_seen.pop_front(), word_of(i));
    endtask : t_fill_read
    task automatic t_refresh_idle();
        int   r0;
        logic bad;
        r0  = ref_count;
        bad = 1'b0;
        repeat (3 * REF_G)
        begin
            @(posedge core_clk);
            if (data_lines_oe_n !== 1'b1 || parity_lines_oe_n !== 1'b1 || rd_valid !== 1'b0)
                bad = 1'b1;
        end
        check(36'(ref_count - r0 >= 2), 36'h1);
        check(36'(bad), 36'h0);
    endtask : t_refresh_idle
    initial
    begin
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'b0;
        t_reset_init();
        t_fill_write();
        t_fill_read();
        t_refresh_idle();
        check(36'(err_count), 36'h0);
        final_report();
    end
    // The whole run needs well under a fifth of this span.
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
endmodule : async_dram_module_access_bench
